// ===== rtl/udir_regs.sv
// Purpose: init and configuration registers of a usb device controller
// Assumes: command port and usb events on the core clock, one word per access
// Notes: lower byte of hardware config not held here, reads as zero
// Behaviour
// - endpoint bit 7 reads 1 only when enabled and memory allocated.
// - endpoint bit 6 gives direction and dma transfer direction.
// - endpoint bit 5 selects double buffering.
// - endpoint bit 4 selects isochronous, else bulk or interrupt.
// - endpoint bits 3 to 0 select fifo size code.
// - bus reset makes active address zero and enables device.
// - bus reset leaves the readable address register unchanged.
// - new address becomes active only after host acknowledges status packet.
// - address bit 7 enables device, bits 6 to 0 hold address.
// - address written with b6, read with b7, one word each.
// - mode register is one byte, upper byte of word ignored.
// - mode bit 7 selects 16-bit dma width, kept on bus reset.
// - writing mode bit 5 as 1 then 0 enters suspend.
// - mode bit 3 globally enables interrupts, kept on bus reset.
// - bit 2 set interrupts on nak and error, else ack and iso.
// - mode bit 0 enables pull-up unless external pull-up is marked.
// - bus reset clears mode bits 6 to 4 only; power-up clears all.
// - mode written with b8, read with b9, one word each.
// - hardware config untouched by bus reset; upper byte clock control.
// - hardware config via ba and bb; upper byte resets to 23h.
// - hardware config bit 14 marks external pull-up fitted.
// - clock output half period is divisor plus one cycles, without glitches.
// - bit 13 clear gives slow clock after delay, set disables output.
`timescale 1ns/1ps
module udir_regs
   import udir_pkg::*;
#(
   parameter int SUSP_DELAY = SUSP_DELAY_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire udir_cmd_s cmd,
   input wire logic usb_bus_reset,
   input wire logic status_ack,
   input wire logic wake_event,
   input wire logic token_valid,
   input wire logic [6:0] token_addr,
   input wire udir_usb_ev_s usb_ev,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output udir_ep_cfg_s [EP_COUNT-1:0] ep_cfg,
   output logic fifo_alloc_done,
   output logic device_enable,
   output logic [6:0] active_address,
   output logic token_match,
   output logic dma_width_select,
   output logic irq_global_enable,
   output logic dc_irq_pulse,
   output logic soft_attach_pullup,
   output logic suspended,
   output logic clocks_stopped,
   output logic clock_output_pin
);

   udir_ep_cfg_s [EP_COUNT-1:0] ep_reg;
   logic alloc_reg;
   logic [7:0] addr_reg;
   logic addr_pend_reg;
   logic [6:0] act_addr_reg;
   logic act_en_reg;
   logic [7:0] mode_reg;
   logic [7:0] hw_hi_reg;
   logic [15:0] rd_data_reg;
   logic rd_valid_reg;
   logic match_reg;
   logic irq_reg;
   logic pull_reg;
   udir_susp_e susp_reg;
   udir_susp_e susp_next;
   logic [16:0] susp_cnt_reg;
   logic clock_output_pin_run;

   // command decode
   wire logic wr = cmd.valid && cmd.write;
   wire logic rd = cmd.valid && !cmd.write;
   wire logic ep_wr = wr && (cmd.code[7:4] == CMD_EP_WR_BASE[7:4]);
   wire logic ep_rd = rd && (cmd.code[7:4] == CMD_EP_RD_BASE[7:4]);
   wire logic [3:0] ep_idx = cmd.code[3:0] & CMD_EP_HIGH_MASK;
   wire logic addr_wr = wr && (cmd.code == CMD_ADDR_WR);
   wire logic addr_rd = rd && (cmd.code == CMD_ADDR_RD);
   wire logic mode_wr = wr && (cmd.code == CMD_MODE_WR);
   wire logic mode_rd = rd && (cmd.code == CMD_MODE_RD);
   wire logic hw_wr = wr && (cmd.code == CMD_HWCFG_WR);
   wire logic hw_rd = rd && (cmd.code == CMD_HWCFG_RD);
   wire logic [7:0] wbyte = cmd.wdata[7:0];
   wire logic [7:0] hw_wbyte = cmd.wdata[15:8];

   wire logic [7:0] ep_rd_byte = {ep_reg[ep_idx].fifo_enable && alloc_reg,
                                  ep_reg[ep_idx][EP_FIFO_EN_BIT-1:0]};
   wire logic [15:0] rd_next = ep_rd ? {8'h00, ep_rd_byte} :
                               addr_rd ? {8'h00, addr_reg} :
                               mode_rd ? {8'h00, mode_reg} :
                               hw_rd ? {hw_hi_reg, 8'h00} : 16'h0000;

   // suspend request: bit 5 written 0 after being 1
   wire logic susp_req = mode_wr && mode_reg[MODE_SUSP_BIT] && !wbyte[MODE_SUSP_BIT];
   wire logic susp_done = (susp_cnt_reg == 17'(SUSP_DELAY - 1));
   wire logic [7:0] mode_after_bus_reset = mode_reg & MODE_BUSRST_KEEP;
   wire logic ext_pullup = hw_hi_reg[HW_EXTERNAL_PULLUP_USED_BIT];
   wire logic irq_src = mode_reg[MODE_DBG_BIT] ? (usb_ev.nak || usb_ev.error) :
                        (usb_ev.ack_bulk || usb_ev.iso_done);

   genvar gi;
   generate
      for (gi = 0; gi < EP_COUNT; gi++) begin : g_ep
         always_ff @(posedge clk) begin
            if (srst) begin
               ep_reg[gi] <= EP_RESET;
            end else if (ep_wr && ep_idx == 4'(gi)) begin
               ep_reg[gi] <= wbyte;
            end else if (usb_bus_reset) begin
               ep_reg[gi].fifo_enable <= 1'b0;
            end
         end
      end
   endgenerate

   // memory allocation runs once the last endpoint has been configured
   always_ff @(posedge clk) begin
      if (srst || usb_bus_reset) begin
         alloc_reg <= 1'b0;
      end else if (ep_wr) begin
         alloc_reg <= (ep_idx == EP_LAST);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         addr_reg <= ADDR_RESET;
      end else if (addr_wr) begin
         addr_reg <= wbyte;
      end
   end

   // active address: bus reset wins, then an address write, then the deferred update
   always_ff @(posedge clk) begin
      if (srst) begin
         act_addr_reg <= ADDR_BUS_RESET;
         act_en_reg <= 1'b0;
         addr_pend_reg <= 1'b0;
      end else if (usb_bus_reset) begin
         act_addr_reg <= ADDR_BUS_RESET;
         act_en_reg <= 1'b1;
         addr_pend_reg <= 1'b0;
      end else if (addr_wr) begin
         act_en_reg <= wbyte[ADDR_EN_BIT];
         addr_pend_reg <= 1'b1;
      end else if (addr_pend_reg && status_ack) begin
         act_addr_reg <= addr_reg[6:0];
         addr_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_reg <= MODE_RESET;
      end else if (mode_wr) begin
         mode_reg <= wbyte;
      end else if (usb_bus_reset) begin
         mode_reg <= mode_after_bus_reset;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hw_hi_reg <= HW_HI_RESET;
      end else if (hw_wr) begin
         hw_hi_reg <= hw_wbyte;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data_reg <= 16'h0000;
         rd_valid_reg <= 1'b0;
         match_reg <= 1'b0;
         irq_reg <= 1'b0;
         pull_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_next;
         rd_valid_reg <= rd;
         match_reg <= token_valid && act_en_reg && (token_addr == act_addr_reg);
         irq_reg <= mode_reg[MODE_IRQEN_BIT] && irq_src;
         pull_reg <= mode_reg[MODE_SOFT_BIT] && !ext_pullup;
      end
   end

   // suspend sequencing with the clock-switch delay
   always_comb begin
      susp_next = susp_reg;
      case (susp_reg)
         SUSP_IDLE: begin
            if (susp_req) begin
               susp_next = SUSP_WAIT;
            end
         end
         SUSP_WAIT: begin
            if (wake_event || usb_bus_reset) begin
               susp_next = SUSP_IDLE;
            end else if (susp_done) begin
               susp_next = SUSP_ACTIVE;
            end
         end
         SUSP_ACTIVE: begin
            if (wake_event || usb_bus_reset) begin
               susp_next = SUSP_IDLE;
            end
         end
         default: begin
            susp_next = SUSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         susp_reg <= SUSP_IDLE;
         susp_cnt_reg <= 17'h00000;
      end else begin
         susp_reg <= susp_next;
         susp_cnt_reg <= (susp_reg == SUSP_WAIT) ? susp_cnt_reg + 17'h00001 : 17'h00000;
      end
   end

   wire logic slow_phase = (susp_reg == SUSP_ACTIVE);
   assign clock_output_pin_run = !(slow_phase && hw_hi_reg[HW_SLOW_CLOCK_DISABLE_BIT]);

   udir_clkdiv u_clkdiv (
      .clk(clk),
      .srst(srst),
      .run(clock_output_pin_run),
      .slow_sel(slow_phase),
      .divisor(hw_hi_reg[HW_DIV_MSB:0]),
      .clk_out(clock_output_pin)
   );

   logic susp_out_reg;
   logic clk_stop_reg;
   always_ff @(posedge clk) begin
      if (srst) begin
         susp_out_reg <= 1'b0;
         clk_stop_reg <= 1'b0;
      end else begin
         susp_out_reg <= (susp_next != SUSP_IDLE);
         clk_stop_reg <= (susp_next == SUSP_ACTIVE) && !hw_hi_reg[HW_CLOCKS_ALWAYS_ON_BIT];
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_valid = rd_valid_reg;
   assign ep_cfg = ep_reg;
   assign fifo_alloc_done = alloc_reg;
   assign device_enable = act_en_reg;
   assign active_address = act_addr_reg;
   assign token_match = match_reg;
   assign dma_width_select = mode_reg[MODE_DMA_WIDTH_SELECT_BIT];
   assign irq_global_enable = mode_reg[MODE_IRQEN_BIT];
   assign dc_irq_pulse = irq_reg;
   assign soft_attach_pullup = pull_reg;
   assign suspended = susp_out_reg;
   assign clocks_stopped = clk_stop_reg;

   property p_bus_reset_addr;
      @(posedge clk) disable iff (srst) usb_bus_reset |=> (act_addr_reg == 7'h00) && act_en_reg;
   endproperty
   a_bus_reset_addr: assert property (p_bus_reset_addr) else $error("active address not cleared");

   property p_addr_reg_kept;
      @(posedge clk) disable iff (srst) (usb_bus_reset && !addr_wr) |=> $stable(addr_reg);
   endproperty
   a_addr_reg_kept: assert property (p_addr_reg_kept) else $error("address register changed");

   property p_addr_deferred;
      @(posedge clk) disable iff (srst)
         (addr_pend_reg && !status_ack && !usb_bus_reset) |=> $stable(act_addr_reg);
   endproperty
   a_addr_deferred: assert property (p_addr_deferred) else $error("address used early");

   property p_addr_applied;
      @(posedge clk) disable iff (srst)
         (addr_pend_reg && status_ack && !usb_bus_reset && !addr_wr) |=> act_addr_reg == $past(addr_reg[6:0]);
   endproperty
   a_addr_applied: assert property (p_addr_applied) else $error("address not applied");

   property p_mode_bus_reset;
      @(posedge clk) disable iff (srst)
         (usb_bus_reset && !mode_wr) |=> (mode_reg[6:4] == 3'b000) && (mode_reg[7] == $past(mode_reg[7]))
            && (mode_reg[3:0] == $past(mode_reg[3:0]));
   endproperty
   a_mode_bus_reset: assert property (p_mode_bus_reset) else $error("mode bus reset wrong");

   property p_suspend_entry;
      @(posedge clk) disable iff (srst)
         (susp_req && susp_reg == SUSP_IDLE) |=> suspended ##1 (suspended || wake_event || usb_bus_reset);
   endproperty
   a_suspend_entry: assert property (p_suspend_entry) else $error("suspend not entered");

   property p_ext_pullup;
      @(posedge clk) disable iff (srst) ext_pullup ##1 $stable(hw_hi_reg) |-> !soft_attach_pullup;
   endproperty
   a_ext_pullup: assert property (p_ext_pullup) else $error("pull-up on with external");

   property p_token_match;
      @(posedge clk) disable iff (srst)
         token_valid |=> token_match == ($past(act_en_reg) && $past(token_addr) == $past(act_addr_reg));
   endproperty
   a_token_match: assert property (p_token_match) else $error("token match wrong");

   property p_debug_irq;
      @(posedge clk) disable iff (srst)
         (mode_reg[MODE_IRQEN_BIT] && mode_reg[MODE_DBG_BIT] && usb_ev.nak) |=> dc_irq_pulse;
   endproperty
   a_debug_irq: assert property (p_debug_irq) else $error("nak irq missing");

   property p_addr_read;
      @(posedge clk) disable iff (srst) addr_rd |=> rd_valid && rd_data == {8'h00, $past(addr_reg)};
   endproperty
   a_addr_read: assert property (p_addr_read) else $error("address readback wrong");

   property p_hw_kept;
      @(posedge clk) disable iff (srst) (usb_bus_reset && !hw_wr) |=> $stable(hw_hi_reg);
   endproperty
   a_hw_kept: assert property (p_hw_kept) else $error("hardware config changed");

endmodule : udir_regs

// ===== pkg/udir_pkg.sv
// Purpose: constants and carriers for the usb device init register block
// Assumes: 40 MHz core clock, command-coded one-word register access
// Notes: endpoint config struct follows the register bit layout msb first
package udir_pkg;

   localparam logic [7:0] CMD_EP_WR_BASE = 8'h20;
   localparam logic [7:0] CMD_EP_RD_BASE = 8'h30;
   localparam logic [7:0] CMD_ADDR_WR = 8'hb6;
   localparam logic [7:0] CMD_ADDR_RD = 8'hb7;
   localparam logic [7:0] CMD_MODE_WR = 8'hb8;
   localparam logic [7:0] CMD_MODE_RD = 8'hb9;
   localparam logic [7:0] CMD_HWCFG_WR = 8'hba;
   localparam logic [7:0] CMD_HWCFG_RD = 8'hbb;
   localparam logic [3:0] CMD_EP_HIGH_MASK = 4'hf;

   localparam int EP_COUNT = 16;
   localparam logic [3:0] EP_FIRST = 4'h0;
   localparam logic [3:0] EP_LAST = 4'hf;
   localparam int EP_FIFO_EN_BIT = 7;
   localparam logic [7:0] EP_RESET = 8'h00;

   localparam int ADDR_EN_BIT = 7;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [6:0] ADDR_BUS_RESET = 7'h00;

   localparam int MODE_DMA_WIDTH_SELECT_BIT = 7;
   localparam int MODE_SUSP_BIT = 5;
   localparam int MODE_IRQEN_BIT = 3;
   localparam int MODE_DBG_BIT = 2;
   localparam int MODE_SOFT_BIT = 0;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODE_BUSRST_KEEP = 8'h8f;

   // upper byte of hardware config, bit positions within that byte
   localparam int HW_EXTERNAL_PULLUP_USED_BIT = 6;
   localparam int HW_SLOW_CLOCK_DISABLE_BIT = 5;
   localparam int HW_CLOCKS_ALWAYS_ON_BIT = 4;
   localparam int HW_DIV_MSB = 3;
   localparam logic [7:0] HW_HI_RESET = 8'h23;

   localparam int CLK_FREQ_HZ = 40_000_000;
   localparam int SUSP_DELAY_US = 2000;
   localparam int SUSP_DELAY_CYC = (CLK_FREQ_HZ / 1_000_000) * SUSP_DELAY_US;
   localparam int SLOW_CLK_HZ = 100_000;
   localparam int SLOW_HALF_CYC = CLK_FREQ_HZ / (2 * SLOW_CLK_HZ);

   typedef struct packed {
      logic fifo_enable;
      logic endpoint_direction;
      logic double_buffer;
      logic isochronous_type;
      logic [3:0] buffer_size_select;
   } udir_ep_cfg_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] wdata;
   } udir_cmd_s;

   typedef struct packed {
      logic ack_bulk;
      logic iso_done;
      logic nak;
      logic error;
   } udir_usb_ev_s;

   typedef enum logic [2:0] {
      SUSP_IDLE = 3'b001,
      SUSP_WAIT = 3'b010,
      SUSP_ACTIVE = 3'b100
   } udir_susp_e;

endpackage : udir_pkg

// ===== rtl/udir_clkdiv.sv
// Purpose: glitch-free divided clock output with slow suspend clock
// Assumes: half period measured in core clock cycles
// Notes: new settings load only at the end of a whole period or while run is low
`timescale 1ns/1ps
module udir_clkdiv
   import udir_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic slow_sel,
   input wire logic [3:0] divisor,
   output logic clk_out
);

   logic [7:0] cnt_reg;
   logic [7:0] half_reg;
   logic out_reg;
   wire logic [7:0] half_next = slow_sel ? 8'(SLOW_HALF_CYC - 1) : {4'h0, divisor};
   wire logic wrap = (cnt_reg == half_reg);

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= 8'h00;
         half_reg <= {4'h0, HW_HI_RESET[HW_DIV_MSB:0]};
         out_reg <= 1'b0;
      end else if (!run) begin
         // restart at the programmed rate, no short first half
         cnt_reg <= 8'h00;
         half_reg <= {4'h0, divisor};
         out_reg <= 1'b0;
      end else if (wrap) begin
         cnt_reg <= 8'h00;
         out_reg <= !out_reg;
         // switch only at the end of a whole period: no runt pulse
         if (out_reg) begin
            half_reg <= half_next;
         end
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   assign clk_out = out_reg;

endmodule : udir_clkdiv

// ===== tb/udir_fw_model.sv
// Purpose: firmware side of the command port, one word per access
// Assumes: tasks are entered just after a falling clock edge
// Notes: requests held through the taking rising edge, answers sampled one cycle later
`timescale 1ns/1ps
module udir_fw_model
   import udir_pkg::*;
(
   input wire logic clk,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   output udir_cmd_s cmd,
   output logic status_ack
);
   initial begin
      cmd = '0;
      status_ack = 1'b0;
   end

   task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                         output logic vld, output logic [15:0] rd);
      cmd = '{valid: 1'b1, write: wr, code: code, wdata: wd};
      @(posedge clk);
      @(negedge clk);
      vld = rd_valid;
      rd = rd_data;
      cmd.valid = 1'b0;
      // one idle edge so a following access never re-raises valid at once
      @(negedge clk);
   endtask : access

   task automatic wr(input logic [7:0] code, input logic [15:0] wd);
      logic v;
      logic [15:0] d;
      access(1'b1, code, wd, v, d);
   endtask : wr

   task automatic rd(input logic [7:0] code, output logic v, output logic [15:0] d);
      access(1'b0, code, 16'h0000, v, d);
   endtask : rd

   // host acknowledge of the empty packet sent after an address write
   task automatic send_status();
      status_ack = 1'b1;
      @(posedge clk);
      @(negedge clk);
      status_ack = 1'b0;
   endtask : send_status

   task automatic suspend_req(input logic [7:0] mode);
      wr(CMD_MODE_WR, {8'h00, mode | 8'h20});
      wr(CMD_MODE_WR, {8'h00, mode & 8'hdf});
   endtask : suspend_req
endmodule : udir_fw_model

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the init register block
// Assumes: inputs change at falling edges, shortened suspend delay
// Notes: the firmware model owns the command port and status acknowledge
`timescale 1ns/1ps
module tb_top
   import udir_pkg::*;
;
   localparam int SD = 20;
   logic clk, srst, usb_bus_reset, wake_event, token_valid, status_ack, rd_valid;
   logic [6:0] token_addr, active_address;
   udir_usb_ev_s usb_ev;
   udir_cmd_s cmd;
   logic [15:0] rd_data;
   udir_ep_cfg_s [EP_COUNT-1:0] ep_cfg;
   logic fifo_alloc_done, device_enable, token_match, dma_width_select, irq_global_enable;
   logic dc_irq_pulse, soft_attach_pullup, suspended, clocks_stopped, clock_output_pin;
   int err_count = 0;
   int total_checks = 0;

   udir_regs #(.SUSP_DELAY(SD)) DUT (.clk(clk), .srst(srst), .cmd(cmd),
      .usb_bus_reset(usb_bus_reset), .status_ack(status_ack), .wake_event(wake_event),
      .token_valid(token_valid), .token_addr(token_addr), .usb_ev(usb_ev),
      .rd_data(rd_data), .rd_valid(rd_valid), .ep_cfg(ep_cfg),
      .fifo_alloc_done(fifo_alloc_done), .device_enable(device_enable),
      .active_address(active_address), .token_match(token_match),
      .dma_width_select(dma_width_select), .irq_global_enable(irq_global_enable),
      .dc_irq_pulse(dc_irq_pulse), .soft_attach_pullup(soft_attach_pullup),
      .suspended(suspended), .clocks_stopped(clocks_stopped),
      .clock_output_pin(clock_output_pin));

   udir_fw_model fw (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd),
      .status_ack(status_ack));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic print_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] code, input logic [15:0] exp, input string nm);
      logic v;
      logic [15:0] d;
      fw.rd(code, v, d);
      chk({nm, " valid"}, 16'h0001, {15'h0000, v});
      chk(nm, exp, d);
   endtask : rdchk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   task automatic bus_reset();
      usb_bus_reset = 1'b1;
      cyc(1);
      usb_bus_reset = 1'b0;
   endtask : bus_reset

   task automatic t_reset_values();
      rdchk(CMD_ADDR_RD, 16'h0000, "addr");
      rdchk(CMD_MODE_RD, 16'h0000, "mode");
      rdchk(CMD_HWCFG_RD, 16'h2300, "hwcfg");
      rdchk(8'h55, 16'h0000, "unmapped");
   endtask : t_reset_values

   task automatic t_address();
      fw.wr(CMD_ADDR_WR, 16'hff85);
      chk("dev_en", 16'h1, {15'h0, device_enable});
      chk("active early", 16'h0, {9'h0, active_address});
      rdchk(CMD_ADDR_RD, 16'h0085, "addr");
      fw.send_status();
      chk("active", 16'h5, {9'h0, active_address});
      token_valid = 1'b1;
      for (int a = 5; a < 7; a++) begin
         token_addr = 7'(a);
         cyc(1);
         chk("token_match", {15'h0, a == 5}, {15'h0, token_match});
      end
      token_valid = 1'b0;
      fw.wr(CMD_ADDR_WR, 16'h0033);
      fw.send_status();
      chk("dev_en off", 16'h0, {15'h0, device_enable});
      bus_reset();
      chk("active rst", 16'h0, {9'h0, active_address});
      chk("dev_en rst", 16'h1, {15'h0, device_enable});
      rdchk(CMD_ADDR_RD, 16'h0033, "addr rst");
   endtask : t_address

   task automatic t_mode_hw();
      fw.wr(CMD_MODE_WR, 16'hffbd);
      rdchk(CMD_MODE_RD, 16'h00bd, "mode");
      fw.wr(CMD_HWCFG_WR, 16'h5aff);
      rdchk(CMD_HWCFG_RD, 16'h5a00, "hwcfg");
      bus_reset();
      rdchk(CMD_MODE_RD, 16'h008d, "mode rst");
      chk("dma_w", 16'h1, {15'h0, dma_width_select});
      chk("irq_en", 16'h1, {15'h0, irq_global_enable});
      rdchk(CMD_HWCFG_RD, 16'h5a00, "hwcfg rst");
      chk("pullup ext", 16'h0, {15'h0, soft_attach_pullup});
      fw.wr(CMD_HWCFG_WR, 16'h2300);
      cyc(1);
      chk("pullup int", 16'h1, {15'h0, soft_attach_pullup});
   endtask : t_mode_hw

   task automatic t_irq();
      logic [7:0] m;
      for (int j = 0; j < 3; j++) begin
         m = (j == 0) ? 8'h08 : (j == 1) ? 8'h0c : 8'h00;
         fw.wr(CMD_MODE_WR, {8'h00, m});
         for (int k = 0; k < 4; k++) begin
            usb_ev = udir_usb_ev_s'(4'h8 >> k);
            cyc(1);
            chk("irq", {15'h0, m[3] && (m[2] == (k >= 2))}, {15'h0, dc_irq_pulse});
         end
         usb_ev = '0;
      end
   endtask : t_irq

   task automatic t_endpoint();
      logic [7:0] v;
      for (int i = 0; i < EP_COUNT; i++) begin
         fw.wr(CMD_EP_WR_BASE + 8'(i), {8'h00, 1'b1, 3'(i), 4'(i)});
      end
      chk("alloc", 16'h1, {15'h0, fifo_alloc_done});
      for (int i = 0; i < EP_COUNT; i++) begin
         v = {1'b1, 3'(i), 4'(i)};
         chk("ep_cfg", {8'h0, v}, {8'h0, ep_cfg[i]});
         rdchk(CMD_EP_RD_BASE + 8'(i), {8'h0, v}, "ep");
      end
      fw.wr(CMD_EP_WR_BASE + 8'h3, 16'h00b3);
      rdchk(CMD_EP_RD_BASE + 8'h5, 16'h0055, "ep realloc");
      bus_reset();
      chk("ep_cfg rst", 16'h0055, {8'h0, ep_cfg[5]});
   endtask : t_endpoint

   task automatic t_clock();
      int n;
      logic p;
      for (int d = 1; d < 5; d += 3) begin
         fw.wr(CMD_HWCFG_WR, {4'h2, 4'(d), 8'h00});
         cyc(40);
         p = clock_output_pin;
         for (int t = 0; t < 64 && clock_output_pin === p; t++) cyc(1);
         n = 0;
         p = clock_output_pin;
         for (int t = 0; t < 64 && clock_output_pin === p; t++) begin
            cyc(1);
            n++;
         end
         chk("half period", 16'(d + 1), 16'(n));
      end
   endtask : t_clock

   task automatic t_suspend();
      int n;
      logic p;
      fw.wr(CMD_HWCFG_WR, 16'h0300);
      fw.suspend_req(8'h00);
      chk("susp", 16'h1, {15'h0, suspended});
      cyc(5);
      chk("stop early", 16'h0, {15'h0, clocks_stopped});
      cyc(SD);
      chk("stopped", 16'h1, {15'h0, clocks_stopped});
      cyc(20);
      p = clock_output_pin;
      for (int t = 0; t < 450 && clock_output_pin === p; t++) cyc(1);
      n = 0;
      p = clock_output_pin;
      for (int t = 0; t < 450 && clock_output_pin === p; t++) begin
         cyc(1);
         n++;
      end
      chk("slow half", 16'(SLOW_HALF_CYC), 16'(n));
      wake_event = 1'b1;
      cyc(1);
      wake_event = 1'b0;
      chk("woken", 16'h0, {15'h0, suspended});
      fw.wr(CMD_HWCFG_WR, 16'h3300);
      fw.suspend_req(8'h00);
      cyc(SD + 5);
      chk("kept run", 16'h0, {15'h0, clocks_stopped});
      for (int t = 0; t < 12; t++) begin
         cyc(1);
         chk("clock_output_pin off", 16'h0, {15'h0, clock_output_pin});
      end
      bus_reset();
      chk("rst wake", 16'h0, {15'h0, suspended});
   endtask : t_suspend

   initial begin
      srst = 1'b1;
      usb_bus_reset = 1'b0;
      wake_event = 1'b0;
      token_valid = 1'b0;
      token_addr = 7'h00;
      usb_ev = '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      cyc(1);
      t_reset_values();
      t_address();
      t_mode_hw();
      t_irq();
      t_endpoint();
      t_clock();
      t_suspend();
      print_verdict();
   end

   initial begin
      #(25 * 10000);
      err_count++;
      print_verdict();
   end
endmodule : tb_top
